// File: hw/qbp_regs.vh
// Purpose: offsets, field positions, reset values and mode codes of the port pin block
// Assumes: apb byte addresses, one aligned 32-bit word per register
// Notes:   mode codes are per pin, two bits each
`ifndef QBP_REGS_VH
`define QBP_REGS_VH

`define QBP_ADDR_W          12
`define QBP_OFF_PORT_ONE    12'h090
`define QBP_OFF_PORT_THREE  12'h0B0
`define QBP_OFF_PORT_FOUR   12'h0C0
`define QBP_OFF_FSEL_ONE    12'h100
`define QBP_OFF_FSEL_THREE  12'h104
`define QBP_OFF_FSEL_FOUR   12'h108
`define QBP_OFF_BITOP       12'h10C
`define QBP_LATCH_RST       8'hFF
`define QBP_FSEL_RST        16'h0000
`define QBP_FSEL_W          16
`define QBP_BITOP_SET       2'b01
`define QBP_BITOP_CLR       2'b10
`define QBP_BITOP_CPL       2'b11
`define QBP_BITOP_FN_LSB    8
`define QBP_BITOP_PORT_LSB  4
`define QBP_BITOP_RMW_BIT   16
`define QBP_FN_GPIO         2'b00
`define QBP_FN_QUASI        2'b01
`define QBP_FN_SPECIAL      2'b10
`define QBP_FN_INPUT        2'b11

`endif

// File: hw/qbp_pin_cell.v
// Purpose: one port pin cell: drivers, pull-ups and pin sense for a single pin
// Assumes: pin input is synchronous to pclk
// Notes:   special mode is analog on port one, open drain on three, push-pull on four
`timescale 1ns/1ps
`include "qbp_regs.vh"
module qbp_pin_cell #(
    parameter PORT_KIND = 0
) (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       latch_bit,
    input  wire       alt_bit,
    input  wire [1:0] mode,
    input  wire       pin_in,
    output reg        low_drive,
    output reg        high_drive,
    output reg        pullup_strong,
    output reg        pullup_weak,
    output wire       pin_level,
    output wire       pin_oe_n
);
    wire       drv_bit;
    wire       is_special;
    wire       is_input;
    reg        drv_delay_q;
    wire       rise;

    assign drv_bit    = (mode == `QBP_FN_GPIO) ? latch_bit : (alt_bit & latch_bit);
    assign is_special = (mode == `QBP_FN_SPECIAL);
    assign is_input   = (mode == `QBP_FN_INPUT);
    // delay element on the driven value finds the 0-to-1 change
    assign rise       = drv_bit & ~drv_delay_q;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            drv_delay_q <= 1'b1;
        else
            drv_delay_q <= drv_bit;
    end

    always @*
    begin
        low_drive     = 1'b0;
        high_drive    = 1'b0;
        pullup_strong = 1'b0;
        pullup_weak   = 1'b0;
        if (is_special && PORT_KIND == 0)
        begin
            low_drive = 1'b0;
        end
        else if (is_special && PORT_KIND == 2)
        begin
            low_drive  = ~drv_bit;
            high_drive = drv_bit;
        end
        else if (is_input || drv_bit)
        begin
            // one cycle strong high, none for open drain
            high_drive    = rise & ~is_input & ~(is_special && PORT_KIND == 1);
            pullup_weak   = 1'b1;
            // strong pull-up drops once the pin is pulled low
            pullup_strong = pin_in;
        end
        else
        begin
            low_drive = 1'b1;
        end
    end

    // level seen by the core: the low driver masks the pin
    assign pin_level = pin_in & ~low_drive;
    assign pin_oe_n  = ~(low_drive | high_drive);
endmodule // qbp_pin_cell

// File: hw/qbp_port_pins.v
// Purpose: three 8-bit quasi-bidirectional ports with latches, function select and apb access
// Assumes: apb slave, zero wait states, pins synchronous to pclk
// Notes:   reads return pins unless pwdata bit 16 on the read asks for the latch
//
// Summary of operation
// - three 8-bit ports, inputs during/after reset
// - pin mode follows assigned function
// - written zero drives low, releases pull-ups
// - written one: one-cycle high drive, weak pull-ups
// - high drive only on rising edge of the driven bit (latch, gated by alt_out outside gpio mode), except push-pull on port four
// - weak pull-ups stay on after strong drive
// - zero latch masks pin, reads zero
// - reset loads all latches with ones
// - strong pull-up releases when pin pulled low
// - read-modify-write reads the latch
// - other reads sample pin levels
// - each pin routed independently at run time
// - single-bit and whole-byte latch access
// - function selects clear on reset
// - open drain skips one-cycle high drive
`timescale 1ns/1ps
`include "qbp_regs.vh"
module qbp_port_pins (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire [23:0] alt_out,
    output wire [23:0] pin_level,
    input  wire [23:0] pin_in,
    output wire [23:0] pin_out,
    output wire [23:0] pin_oe_n,
    output wire [23:0] low_drive,
    output wire [23:0] high_drive,
    output wire [23:0] pullup_strong,
    output wire [23:0] pullup_weak
);
    reg  [23:0] latch_q;
    reg  [`QBP_FSEL_W-1:0] fsel_one_q;
    reg  [`QBP_FSEL_W-1:0] fsel_three_q;
    reg  [`QBP_FSEL_W-1:0] fsel_four_q;
    wire [47:0] fsel_all;
    wire        wr_en;
    wire        rd_en;
    wire        hit_latch;
    wire        hit_fsel;
    wire        hit_bitop;
    wire [1:0]  port_idx;
    wire [1:0]  bit_fn;
    wire [1:0]  bit_port;
    wire [2:0]  bit_sel;
    wire [4:0]  bit_pos;
    reg  [31:0] rd_mux;
    reg  [7:0]  port_val;

    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & ~penable & ~pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    assign hit_latch = (paddr == `QBP_OFF_PORT_ONE) || (paddr == `QBP_OFF_PORT_THREE)
                     || (paddr == `QBP_OFF_PORT_FOUR);
    assign hit_fsel  = (paddr == `QBP_OFF_FSEL_ONE) || (paddr == `QBP_OFF_FSEL_THREE)
                     || (paddr == `QBP_OFF_FSEL_FOUR);
    assign hit_bitop = (paddr == `QBP_OFF_BITOP);
    assign port_idx  = (paddr == `QBP_OFF_PORT_ONE || paddr == `QBP_OFF_FSEL_ONE) ? 2'd0 :
                       (paddr == `QBP_OFF_PORT_THREE || paddr == `QBP_OFF_FSEL_THREE) ? 2'd1 :
                       2'd2;

    assign bit_sel  = pwdata[2:0];
    assign bit_port = pwdata[`QBP_BITOP_PORT_LSB+1:`QBP_BITOP_PORT_LSB];
    assign bit_fn   = pwdata[`QBP_BITOP_FN_LSB+1:`QBP_BITOP_FN_LSB];
    assign bit_pos  = {bit_port, bit_sel};

    assign fsel_all = {fsel_four_q, fsel_three_q, fsel_one_q};

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            latch_q      <= {`QBP_LATCH_RST, `QBP_LATCH_RST, `QBP_LATCH_RST};
            fsel_one_q   <= `QBP_FSEL_RST;
            fsel_three_q <= `QBP_FSEL_RST;
            fsel_four_q  <= `QBP_FSEL_RST;
        end
        else if (wr_en)
        begin
            if (hit_latch && pstrb[0])
            begin
                case (port_idx)
                    2'd0:    latch_q[7:0]   <= pwdata[7:0];
                    2'd1:    latch_q[15:8]  <= pwdata[7:0];
                    default: latch_q[23:16] <= pwdata[7:0];
                endcase
            end
            if (hit_fsel)
            begin
                case (port_idx)
                    2'd0:    fsel_one_q   <= pwdata[15:0];
                    2'd1:    fsel_three_q <= pwdata[15:0];
                    default: fsel_four_q  <= pwdata[15:0];
                endcase
            end
            if (hit_bitop && bit_port != 2'd3)
            begin
                case (bit_fn)
                    `QBP_BITOP_SET: latch_q[bit_pos] <= 1'b1;
                    `QBP_BITOP_CLR: latch_q[bit_pos] <= 1'b0;
                    `QBP_BITOP_CPL: latch_q[bit_pos] <= ~latch_q[bit_pos];
                    default:        latch_q[bit_pos] <= latch_q[bit_pos];
                endcase
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 24; gi = gi + 1)
        begin : g_pin
            qbp_pin_cell #(
                .PORT_KIND (gi / 8)
            ) u_cell (
                .pclk          (pclk),
                .presetn       (presetn),
                .latch_bit     (latch_q[gi]),
                .alt_bit       (alt_out[gi]),
                .mode          (fsel_all[2*gi+1:2*gi]),
                .pin_in        (pin_in[gi]),
                .low_drive     (low_drive[gi]),
                .high_drive    (high_drive[gi]),
                .pullup_strong (pullup_strong[gi]),
                .pullup_weak   (pullup_weak[gi]),
                .pin_level     (pin_level[gi]),
                .pin_oe_n      (pin_oe_n[gi])
            );
            assign pin_out[gi] = high_drive[gi];
        end
    endgenerate

    // an rmw read flags itself on pwdata bit 16 and gets the latch back
    always @*
    begin
        port_val = 8'h00;
        case (port_idx)
            2'd0:    port_val = pwdata[`QBP_BITOP_RMW_BIT] ? latch_q[7:0] : pin_level[7:0];
            2'd1:    port_val = pwdata[`QBP_BITOP_RMW_BIT] ? latch_q[15:8] : pin_level[15:8];
            default: port_val = pwdata[`QBP_BITOP_RMW_BIT] ? latch_q[23:16] : pin_level[23:16];
        endcase
        rd_mux = 32'h0000_0000;
        if (hit_latch)
            rd_mux = {24'h00_0000, port_val};
        else if (hit_fsel)
        begin
            case (port_idx)
                2'd0:    rd_mux = {16'h0000, fsel_one_q};
                2'd1:    rd_mux = {16'h0000, fsel_three_q};
                default: rd_mux = {16'h0000, fsel_four_q};
            endcase
        end
        else if (hit_bitop)
            rd_mux = {8'h00, latch_q};
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_en)
            prdata <= rd_mux;
    end
endmodule // qbp_port_pins

// File: tb/qbp_props.sv
// Purpose: drive and sense relations of the port pins
// Assumes: bound to qbp_port_pins
// Notes:   pulse width masked by the weak pull-up, push-pull holds high without it
`timescale 1ns/1ps
module qbp_props (
    input wire        pclk,
    input wire        presetn,
    input wire [23:0] pin_in,
    input wire [23:0] pin_level,
    input wire [23:0] low_drive,
    input wire [23:0] high_drive,
    input wire [23:0] pullup_strong,
    input wire [23:0] pullup_weak
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    rst_state_a: assert property ($rose(presetn) |->
        (pullup_weak == 24'hFF_FFFF) && (low_drive == 24'h00_0000))
        else $error("pins not input ready after reset");
    low_only_a: assert property ((low_drive & (high_drive | pullup_weak | pullup_strong))
        == 24'h00_0000)
        else $error("low driver overlaps pull-up");
    pulse_width_a: assert property ((high_drive & pullup_weak & $past(high_drive))
        == 24'h00_0000)
        else $error("high drive longer than one cycle");
    pulse_cause_a: assert property ((high_drive[15:0] & ~$past(low_drive[15:0])) == 16'h0000)
        else $error("high drive without prior low");
    weak_hold_a: assert property (high_drive[15:0] != 16'h0000 |=>
        (pullup_weak[15:0] & $past(high_drive[15:0])) == $past(high_drive[15:0]))
        else $error("weak pull-up dropped after pulse");
    pin_mask_a: assert property ((pin_level & low_drive) == 24'h00_0000)
        else $error("pin read not masked by low driver");
    pin_sense_a: assert property (((pin_level ^ pin_in) & ~low_drive) == 24'h00_0000)
        else $error("pin read differs from pin");
    strong_off_a: assert property ((pullup_strong & ~pin_in) == 24'h00_0000)
        else $error("strong pull-up on against low pin");
    cover property (high_drive[7:0] == 8'hFF);
    cover property (low_drive[7:0] == 8'hFF);
    cover property (pullup_weak[3] && !pullup_strong[3]);
endmodule // qbp_props
bind qbp_port_pins qbp_props i_props (.pclk, .presetn, .pin_in, .pin_level, .low_drive,
    .high_drive, .pullup_strong, .pullup_weak);

// File: tb/qbp_pin_partner.sv
// Purpose: external devices on the 24 pins
// Assumes: low driver wins any contention
// Notes:   an undriven, unpulled pin toggles each cycle
`timescale 1ns/1ps
module qbp_pin_partner (
    input  wire        pclk,
    input  wire [23:0] ext_en,
    input  wire [23:0] ext_val,
    input  wire [23:0] low_drive,
    input  wire [23:0] high_drive,
    input  wire [23:0] pullup_weak,
    output wire [23:0] pin_in
);
    reg  [23:0] float_q = 24'h00_0000;
    wire [23:0] pulled = high_drive | pullup_weak;
    always @(posedge pclk)
    begin
        float_q <= ~float_q;
    end
    assign pin_in = ~low_drive & ((ext_en & ext_val) | (~ext_en & (pulled | float_q)));
endmodule // qbp_pin_partner

// File: tb/testbench.sv
// Purpose: apb sequences against the port pins
// Assumes: zero wait apb, reads with bit 16 set return latches
// Notes:   hd samples high_drive in the cycle after each write lands
`timescale 1ns/1ps
`include "qbp_regs.vh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error %s exp %h got %h", n, e, g); end end
module testbench;
    reg         pclk = 1'b0;
    reg         presetn = 1'b0;
    reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0000_0000;
    reg  [3:0]  pstrb = 4'hF;
    reg  [23:0] alt_out = 24'h00_0000, ext_en = 24'h00_0000, ext_val = 24'h00_0000;
    wire        pready, pslverr;
    wire [31:0] prdata;
    wire [23:0] pin_in, pin_level, low_drive, high_drive, pullup_strong, pullup_weak;
    wire [23:0] pin_out, pin_oe_n;
    reg  [23:0] hd;
    reg  [31:0] rd;
    integer     n_mismatch = 0, n_checks = 0;
    qbp_port_pins i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .pready, .prdata, .pslverr, .alt_out, .pin_level, .pin_in, .pin_out, .pin_oe_n,
        .low_drive, .high_drive, .pullup_strong, .pullup_weak);
    qbp_pin_partner i_ext (.pclk, .ext_en, .ext_val, .low_drive, .high_drive, .pullup_weak,
        .pin_in);
    initial
    begin
        forever #2.5 pclk = ~pclk;
    end
    task stop_test;
    begin
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        integer k;
    begin
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 50)
        begin
            @(posedge pclk);
            k = k + 1;
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        #1 hd = high_drive;
        if (k == 50)
        begin
            `CHK("pready", 1'b1, pready)
            stop_test;
        end
        else
            @(posedge pclk);
    end
    endtask
    task rchk(input [11:0] a, input r, input [31:0] e);
    begin
        apb(1'b0, a, {15'h0000, r, 16'h0000});
        `CHK("prdata", e, rd)
    end
    endtask
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(`QBP_OFF_PORT_ONE, 1'b1, 32'h0000_00FF);
        rchk(`QBP_OFF_PORT_THREE, 1'b1, 32'h0000_00FF);
        rchk(`QBP_OFF_PORT_FOUR, 1'b1, 32'h0000_00FF);
        rchk(`QBP_OFF_FSEL_ONE, 1'b0, 32'h0000_0000);
        rchk(`QBP_OFF_PORT_ONE, 1'b0, 32'h0000_00FF);
        apb(1'b1, `QBP_OFF_PORT_ONE, 32'h0000_0000);
        `CHK("low_drive", 16'h00FF, low_drive[15:0])
        `CHK("pulls_off", 8'h00, pullup_weak[7:0] | pullup_strong[7:0])
        `CHK("pin_oe_n", 8'h00, pin_oe_n[7:0])
        ext_en <= 24'h00_00FF;
        ext_val <= 24'h00_00FF;
        rchk(`QBP_OFF_PORT_ONE, 1'b0, 32'h0000_0000);
        apb(1'b1, `QBP_OFF_PORT_ONE, 32'h0000_00FF);
        `CHK("high_drive", 16'h00FF, hd[15:0])
        apb(1'b1, `QBP_OFF_PORT_ONE, 32'h0000_00FF);
        `CHK("high_drive", 16'h0000, hd[15:0])
        `CHK("weak_hold", 8'hFF, pullup_weak[7:0])
        ext_val <= 24'h00_00F7;
        rchk(`QBP_OFF_PORT_ONE, 1'b0, 32'h0000_00F7);
        rchk(`QBP_OFF_PORT_ONE, 1'b1, 32'h0000_00FF);
        `CHK("strong", 2'b01, {pullup_strong[3], pullup_weak[3]})
        apb(1'b1, `QBP_OFF_BITOP, 32'h0000_0212);
        rchk(`QBP_OFF_PORT_THREE, 1'b1, 32'h0000_00FB);
        apb(1'b1, `QBP_OFF_BITOP, 32'h0000_0112);
        `CHK("high_drive", 1'b1, hd[10])
        alt_out <= 24'h00_0100;
        apb(1'b1, `QBP_OFF_FSEL_THREE, 32'h0000_0002);
        apb(1'b1, `QBP_OFF_PORT_THREE, 32'h0000_00FE);
        apb(1'b1, `QBP_OFF_PORT_THREE, 32'h0000_00FF);
        `CHK("open_drain", 2'b01, {hd[8], pullup_weak[8]})
        apb(1'b1, `QBP_OFF_FSEL_ONE, 32'h0000_0002);
        `CHK("analog", 3'b000, {low_drive[0], high_drive[0], pullup_weak[0]})
        rchk(`QBP_OFF_FSEL_ONE, 1'b0, 32'h0000_0002);
        alt_out <= 24'h01_0100;
        apb(1'b1, `QBP_OFF_FSEL_FOUR, 32'h0000_0002);
        `CHK("push_pull", 3'b110, {high_drive[16], pin_out[16], low_drive[16]})
        rchk(12'h200, 1'b0, 32'h0000_0000);
        `CHK("pslverr", 1'b0, pslverr)
        apb(1'b1, `QBP_OFF_PORT_FOUR, 32'h0000_000F);
        `CHK("port_four_low", 8'hF0, low_drive[23:16])
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(`QBP_OFF_PORT_FOUR, 1'b1, 32'h0000_00FF);
        rchk(`QBP_OFF_FSEL_FOUR, 1'b0, 32'h0000_0000);
        rchk(`QBP_OFF_FSEL_THREE, 1'b0, 32'h0000_0000);
        stop_test;
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_mismatch = n_mismatch + 1;
        stop_test;
    end
endmodule // testbench
